/* File: cbt_params.svh */
// constants for the bit timing and output control block
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH
// =============================================
// register indexes, byte address is index * 4
`define CBT_IDX_LSB 2
`define CBT_IDX_MSB 5
`define CBT_IDX_CTRL 4'h0
`define CBT_IDX_STAT 4'h1
`define CBT_IDX_PRESC 4'h6
`define CBT_IDX_SEG 4'h7
`define CBT_IDX_OUT 4'h8
// =============================================
// field positions
`define CBT_CTRL_HOLD 0
`define CBT_CTRL_SLEEP 1
`define CBT_CTRL_MASK 8'h03
`define CBT_PRESC_HI 5
`define CBT_SAM 7
`define CBT_TS2_HI 6
`define CBT_TS2_LO 4
`define CBT_TS1_HI 3
`define CBT_TS1_LO 0
`define CBT_CFG_B_HI 7
`define CBT_CFG_B_LO 5
`define CBT_CFG_A_HI 4
`define CBT_CFG_A_LO 2
`define CBT_MODE_HI 1
`define CBT_MODE_LO 0
// =============================================
// reset values and encodings
`define CBT_CTRL_RST 8'h01
`define CBT_PRESC_RST 8'h00
`define CBT_SEG_RST 8'h00
`define CBT_OUT_RST 8'h00
`define CBT_MODE_BIPHASE 2'h0
`define CBT_MODE_TEST 2'h1
`define CBT_MODE_NORMAL 2'h2
`define CBT_MODE_CLOCK 2'h3
`define CBT_DOMINANT 1'b0
`define CBT_RECESSIVE 1'b1
`endif

/* File: cbt_pkg.sv */
// types shared by the bit timing and output control block
// assumes a 32-bit classic wishbone master with a 6-bit byte address
`default_nettype none
package cbt_pkg;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [5:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} cbt_wb_req_s;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} cbt_wb_rsp_s;
	typedef struct packed {
		logic hi_en;
		logic lo_en;
		logic pol;
	} cbt_pin_cfg_s;
	typedef enum logic [1:0] {
		CBT_PH_IDLE,
		CBT_PH_SYNC,
		CBT_PH_SEG1,
		CBT_PH_SEG2
	} cbt_phase_e;
endpackage
`default_nettype wire

/* File: cbt_pin_driver.sv */
// one bus output stage: high-side and low-side switch with polarity
// assumes the pad resolves pin_out and pin_oe_n into a wire level
`timescale 1ns/1ns
`default_nettype none
module cbt_pin_driver
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire cbt_pkg::cbt_pin_cfg_s cfg,
	input wire logic bit_in,
	input wire logic float_in,
	output logic pin_out,
	output logic pin_oe_n
);
	logic lvl;
	logic hi_on;
	logic lo_on;

	assign lvl = bit_in ^ cfg.pol;
	assign hi_on = cfg.hi_en && lvl && !float_in;
	assign lo_on = cfg.lo_en && !lvl && !float_in;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			pin_out <= 1'b0;
			pin_oe_n <= 1'b1;
		end
		else
		begin
			pin_out <= hi_on;
			pin_oe_n <= !(hi_on || lo_on);
		end
	end

	AST_DRV_FLOAT: assert property (@(posedge clk_sys) disable iff (reset)
		float_in || !(cfg.hi_en || cfg.lo_en) |=> pin_oe_n)
		else $error("output stage drives while it should float");
	AST_DRV_PUSHPULL: assert property (@(posedge clk_sys) disable iff (reset)
		(!float_in && cfg.hi_en && cfg.lo_en) |=>
		(!pin_oe_n && pin_out == $past(lvl)))
		else $error("push-pull level does not follow bit and polarity");
endmodule // cbt_pin_driver
`default_nettype wire

/* File: cbt_bit_timer.sv */
// bit period sequencer: quantum prescaler, sync, segment 1, segment 2
// assumes configuration is static while run is high
`timescale 1ns/1ns
`default_nettype none
module cbt_bit_timer
#(
	parameter int BRP_W = 6,
	parameter int TS1_W = 4,
	parameter int TS2_W = 3
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic run,
	input wire logic [BRP_W-1:0] prescaler,
	input wire logic [TS1_W-1:0] ts1,
	input wire logic [TS2_W-1:0] ts2,
	output logic bit_start,
	output logic sample_pt,
	output logic in_sync
);
	if (TS1_W <= TS2_W || BRP_W < 1)
	begin : g_bad_width
		$error("cbt_bit_timer: segment 1 field must be wider than segment 2");
	end

	cbt_pkg::cbt_phase_e phase_q;
	logic [BRP_W:0] cnt_q;
	logic [TS1_W-1:0] q_q;
	logic tq_end;

	// one quantum is 2 * (prescaler + 1) system clocks
	assign tq_end = (phase_q != cbt_pkg::CBT_PH_IDLE) &&
		(cnt_q == {prescaler, 1'b1});
	assign in_sync = (phase_q == cbt_pkg::CBT_PH_SYNC);

	// =============================================
	// quantum prescaler
	always_ff @(posedge clk_sys)
	begin
		if (reset || !run || phase_q == cbt_pkg::CBT_PH_IDLE || tq_end)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// =============================================
	// bit phase sequence
	always_ff @(posedge clk_sys)
	begin
		if (reset || !run)
		begin
			phase_q <= cbt_pkg::CBT_PH_IDLE;
			q_q <= '0;
			bit_start <= 1'b0;
			sample_pt <= 1'b0;
		end
		else
		begin
			bit_start <= 1'b0;
			sample_pt <= 1'b0;
			case (phase_q)
			cbt_pkg::CBT_PH_IDLE:
			begin
				phase_q <= cbt_pkg::CBT_PH_SYNC;
				bit_start <= 1'b1;
			end
			cbt_pkg::CBT_PH_SYNC:
				if (tq_end)
				begin
					phase_q <= cbt_pkg::CBT_PH_SEG1;
					q_q <= '0;
				end
			cbt_pkg::CBT_PH_SEG1:
				if (tq_end)
				begin
					if (q_q == ts1)
					begin
						phase_q <= cbt_pkg::CBT_PH_SEG2;
						q_q <= '0;
						sample_pt <= 1'b1;
					end
					else
						q_q <= q_q + 1'b1;
				end
			cbt_pkg::CBT_PH_SEG2:
				if (tq_end)
				begin
					if (q_q == {{(TS1_W-TS2_W){1'b0}}, ts2})
					begin
						phase_q <= cbt_pkg::CBT_PH_SYNC;
						bit_start <= 1'b1;
					end
					else
						q_q <= q_q + 1'b1;
				end
			default:
				phase_q <= cbt_pkg::CBT_PH_IDLE;
			endcase
		end
	end

	// =============================================
	// length checks
	logic [15:0] tq_clk;
	logic [15:0] bit_len;
	logic [15:0] smp_len;
	logic [15:0] len_q;
	logic seen_q;

	assign tq_clk = 16'({prescaler, 1'b1}) + 16'h1;
	assign bit_len = 16'(tq_clk * (16'(ts1) + 16'(ts2) + 16'h3));
	assign smp_len = 16'(tq_clk * (16'(ts1) + 16'h2));

	always_ff @(posedge clk_sys)
	begin
		if (reset || !run)
		begin
			len_q <= '0;
			seen_q <= 1'b0;
		end
		else
		begin
			len_q <= bit_start ? 16'h1 : len_q + 16'h1;
			if (bit_start)
				seen_q <= 1'b1;
		end
	end

	AST_BIT_LENGTH: assert property (@(posedge clk_sys) disable iff (reset)
		(bit_start && seen_q && run) |-> len_q == bit_len)
		else $error("bit period length wrong");
	AST_SAMPLE_POS: assert property (@(posedge clk_sys) disable iff (reset)
		(sample_pt && run) |-> len_q == smp_len)
		else $error("sample point not at end of segment 1");
endmodule // cbt_bit_timer
`default_nettype wire

/* File: cbt_top.sv */
// bit timing and output driver control with a wishbone register slave
// assumes tx_bit changes only around bit_start and pins are tri-stated
// outside by the oe_n outputs
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cbt_params.svh"

// Operation
// - segment and output registers accessible only while config hold is set
// - triple_sample_select high takes three samples, low takes one
// - segment before sample lasts quantum times field plus one
// - segment after sample lasts quantum times field plus one
// - sleep without config hold drives recessive level on both outputs
// - config hold floats both output drivers
// - output register holds B config, A config, then 2-bit mode
// - normal mode sends transmit bits on both outputs
// - clock mode: A carries bits, B carries quantum-wide bit clock
// - bi-phase mode floats all outputs on recessive bits
// - bi-phase dominant bits alternate on A and B, A first
// - test mode: A carries bits, B follows comparator output
// - quantum is twice oscillator period times prescaler plus one
// - high switch on for enabled high level, low switch for low
// - transmit 0 is dominant, transmit 1 recessive
module cbt_top
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire cbt_pkg::cbt_wb_req_s wb_req,
	output var cbt_pkg::cbt_wb_rsp_s wb_rsp,
	input wire logic tx_bit,
	input wire logic rx_bus_in,
	input wire logic rx_comparator_out,
	output logic bus_out_a,
	output logic bus_out_a_oe_n,
	output logic bus_out_b,
	output logic bus_out_b_oe_n,
	output logic rx_bit,
	output logic rx_bit_valid,
	output logic bit_start
);
	logic [7:0] ctrl_q;
	logic [7:0] presc_q;
	logic [7:0] seg_q;
	logic [7:0] out_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] rd_byte;
	logic req;
	logic wr_fire;
	logic [3:0] idx;
	logic hold;
	logic sleep;
	logic run;
	logic triple_sample_select;
	logic [1:0] mode;
	logic tx_q;
	logic use_b_q;
	logic next_b_q;
	logic [1:0] rx_hist_q;
	logic rx_bit_q;
	logic rx_valid_q;
	logic maj;
	logic sample_pt;
	logic in_sync;
	logic bit_a;
	logic bit_b;
	logic flt_a;
	logic flt_b;
	cbt_pkg::cbt_pin_cfg_s cfg_a;
	cbt_pkg::cbt_pin_cfg_s cfg_b;

	assign hold = ctrl_q[`CBT_CTRL_HOLD];
	assign sleep = ctrl_q[`CBT_CTRL_SLEEP];
	assign run = !hold && !sleep;
	assign triple_sample_select = seg_q[`CBT_SAM];
	assign mode = out_q[`CBT_MODE_HI:`CBT_MODE_LO];
	assign cfg_a = out_q[`CBT_CFG_A_HI:`CBT_CFG_A_LO];
	assign cfg_b = out_q[`CBT_CFG_B_HI:`CBT_CFG_B_LO];

	// =============================================
	// wishbone slave
	assign req = wb_req.cyc && wb_req.stb;
	assign idx = wb_req.adr[`CBT_IDX_MSB:`CBT_IDX_LSB];
	// writes land on the edge where the master sees ack
	assign wr_fire = req && ack_q && wb_req.we && wb_req.sel[0];
	assign wb_rsp = {ack_q, dat_q};

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			ack_q <= 1'b0;
		else
			ack_q <= req && !ack_q;
	end

	always_comb
	begin
		rd_byte = 8'h00;
		case (idx)
		`CBT_IDX_CTRL:
			rd_byte = ctrl_q;
		`CBT_IDX_STAT:
			rd_byte = {5'h00, next_b_q, tx_q, rx_bit_q};
		`CBT_IDX_PRESC:
			rd_byte = hold ? presc_q : 8'h00;
		`CBT_IDX_SEG:
			rd_byte = hold ? seg_q : 8'h00;
		`CBT_IDX_OUT:
			rd_byte = hold ? out_q : 8'h00;
		default:
			rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			dat_q <= '0;
		else if (req && !ack_q)
			dat_q <= {24'h000000, rd_byte};
	end

	// =============================================
	// registers
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			ctrl_q <= `CBT_CTRL_RST;
		else if (wr_fire && idx == `CBT_IDX_CTRL)
			ctrl_q <= wb_req.dat[7:0] & `CBT_CTRL_MASK;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			presc_q <= `CBT_PRESC_RST;
		else if (wr_fire && idx == `CBT_IDX_PRESC && hold)
			presc_q <= {2'h0, wb_req.dat[`CBT_PRESC_HI:0]};
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			seg_q <= `CBT_SEG_RST;
		else if (wr_fire && idx == `CBT_IDX_SEG && hold)
			seg_q <= wb_req.dat[7:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			out_q <= `CBT_OUT_RST;
		else if (wr_fire && idx == `CBT_IDX_OUT && hold)
			out_q <= wb_req.dat[7:0];
	end

	// =============================================
	// bit sequencer
	cbt_bit_timer #(
		.BRP_W(6),
		.TS1_W(4),
		.TS2_W(3)
	) u_timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.run(run),
		.prescaler(presc_q[`CBT_PRESC_HI:0]),
		.ts1(seg_q[`CBT_TS1_HI:`CBT_TS1_LO]),
		.ts2(seg_q[`CBT_TS2_HI:`CBT_TS2_LO]),
		.bit_start(bit_start),
		.sample_pt(sample_pt),
		.in_sync(in_sync)
	);

	// =============================================
	// transmit bit and bi-phase steering
	always_ff @(posedge clk_sys)
	begin
		if (reset || !run)
			tx_q <= `CBT_RECESSIVE;
		else if (bit_start)
			tx_q <= tx_bit;
	end

	// the alternation restarts with A after every configuration pass
	always_ff @(posedge clk_sys)
	begin
		if (reset || hold)
		begin
			use_b_q <= 1'b0;
			next_b_q <= 1'b0;
		end
		else if (bit_start && mode == `CBT_MODE_BIPHASE &&
			tx_bit == `CBT_DOMINANT)
		begin
			use_b_q <= next_b_q;
			next_b_q <= !next_b_q;
		end
	end

	// =============================================
	// receive sampling
	// the three samples are three consecutive system clocks ending at
	// the sample point, so the spike filter is short at high prescale
	assign maj = (rx_bus_in && rx_hist_q[0]) || (rx_bus_in && rx_hist_q[1]) ||
		(rx_hist_q[0] && rx_hist_q[1]);

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			rx_hist_q <= '0;
		else
			rx_hist_q <= {rx_hist_q[0], rx_bus_in};
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rx_bit_q <= `CBT_RECESSIVE;
			rx_valid_q <= 1'b0;
		end
		else
		begin
			rx_valid_q <= sample_pt;
			if (sample_pt)
				rx_bit_q <= triple_sample_select ? maj : rx_bus_in;
		end
	end

	assign rx_bit = rx_bit_q;
	assign rx_bit_valid = rx_valid_q;

	// =============================================
	// output mode selection
	always_comb
	begin
		bit_a = tx_q;
		bit_b = tx_q;
		flt_a = 1'b0;
		flt_b = 1'b0;
		case (mode)
		`CBT_MODE_NORMAL:
			bit_b = tx_q;
		`CBT_MODE_CLOCK:
			bit_b = in_sync;
		`CBT_MODE_BIPHASE:
		begin
			bit_a = `CBT_DOMINANT;
			bit_b = `CBT_DOMINANT;
			flt_a = tx_q || use_b_q;
			flt_b = tx_q || !use_b_q;
		end
		`CBT_MODE_TEST:
			bit_b = rx_comparator_out;
		default:
			bit_b = tx_q;
		endcase
		if (sleep)
		begin
			bit_a = `CBT_RECESSIVE;
			bit_b = `CBT_RECESSIVE;
			flt_a = 1'b0;
			flt_b = 1'b0;
		end
		if (hold)
		begin
			flt_a = 1'b1;
			flt_b = 1'b1;
		end
	end

	cbt_pin_driver u_drv_a (
		.clk_sys(clk_sys),
		.reset(reset),
		.cfg(cfg_a),
		.bit_in(bit_a),
		.float_in(flt_a),
		.pin_out(bus_out_a),
		.pin_oe_n(bus_out_a_oe_n)
	);

	cbt_pin_driver u_drv_b (
		.clk_sys(clk_sys),
		.reset(reset),
		.cfg(cfg_b),
		.bit_in(bit_b),
		.float_in(flt_b),
		.pin_out(bus_out_b),
		.pin_oe_n(bus_out_b_oe_n)
	);

	// =============================================
	// checks
	logic pp_a;
	logic pp_b;
	assign pp_a = cfg_a.hi_en && cfg_a.lo_en && !cfg_a.pol;
	assign pp_b = cfg_b.hi_en && cfg_b.lo_en && !cfg_b.pol;

	sequence s_clk_arm;
		bit_start && run && mode == `CBT_MODE_CLOCK && pp_b &&
		presc_q == 8'h00;
	endsequence

	// checked at the end of the pulse, so a hold or sleep that cuts the
	// pulse short is excused rather than flagged
	sequence s_clk_pulse;
		$past(bus_out_b) && bus_out_b ##1 !bus_out_b;
	endsequence

	sequence s_two_high;
		rx_bus_in ##1 rx_bus_in;
	endsequence

	AST_LOCKED_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
		(wr_fire && !hold && (idx == `CBT_IDX_SEG || idx == `CBT_IDX_OUT))
		|=> ($stable(seg_q) && $stable(out_q)))
		else $error("configuration changed outside config hold");
	AST_HOLD_FLOAT: assert property (@(posedge clk_sys) disable iff (reset)
		hold |=> (bus_out_a_oe_n && bus_out_b_oe_n))
		else $error("outputs driven during config hold");
	AST_SLEEP_REC: assert property (@(posedge clk_sys) disable iff (reset)
		(sleep && !hold && pp_a) |=> (bus_out_a && !bus_out_a_oe_n))
		else $error("sleep does not drive recessive");
	AST_NORMAL_DOM: assert property (@(posedge clk_sys) disable iff (reset)
		(run && mode == `CBT_MODE_NORMAL && pp_a && pp_b && !tx_q)
		|=> (!bus_out_a && !bus_out_b && !bus_out_a_oe_n))
		else $error("dominant bit not on both outputs");
	AST_CLOCK_OUT: assert property (@(posedge clk_sys) disable iff (reset)
		(s_clk_arm ##1 run [*2]) |-> s_clk_pulse)
		else $error("bit clock pulse not one quantum");
	AST_BIPHASE_FLOAT: assert property (@(posedge clk_sys) disable iff (reset)
		(run && mode == `CBT_MODE_BIPHASE && tx_q)
		|=> (bus_out_a_oe_n && bus_out_b_oe_n))
		else $error("bi-phase recessive bit not floating");
	AST_BIPHASE_ALT: assert property (@(posedge clk_sys) disable iff (reset)
		(run && mode == `CBT_MODE_BIPHASE && !tx_q && pp_a && pp_b)
		|=> (bus_out_a_oe_n == $past(use_b_q) &&
		bus_out_b_oe_n == $past(!use_b_q)))
		else $error("bi-phase dominant on wrong output");
	AST_TEST_LOOP: assert property (@(posedge clk_sys) disable iff (reset)
		(run && mode == `CBT_MODE_TEST && pp_b)
		|=> (bus_out_b == $past(rx_comparator_out)))
		else $error("test mode output B not from comparator");
	AST_MAJORITY: assert property (@(posedge clk_sys) disable iff (reset)
		(s_two_high ##0 (sample_pt && triple_sample_select)) |=> rx_bit)
		else $error("majority vote lost");
	AST_SINGLE: assert property (@(posedge clk_sys) disable iff (reset)
		(sample_pt && !triple_sample_select) |=> (rx_bit == $past(rx_bus_in) && rx_bit_valid))
		else $error("single sample not taken");
endmodule // cbt_top
`default_nettype wire

/* File: cbt_bus_line_model.sv */
// bus line model seen by the two output pins of the driver block
// assumes a pull-up keeps the line recessive while no pin drives low
`timescale 1ns/1ns
`default_nettype none
module cbt_bus_line_model
(
	input wire logic bus_out_a,
	input wire logic bus_out_a_oe_n,
	input wire logic bus_out_b,
	input wire logic bus_out_b_oe_n,
	input wire logic spike,
	output logic rx_bus_in
);
	// =============================================
	// wired line
	logic line_lvl;
	// floating pins are masked by oe_n, so their stale level never leaks
	assign line_lvl = ~((~bus_out_a_oe_n & ~bus_out_a) |
		(~bus_out_b_oe_n & ~bus_out_b));
	// spike lets the bench disturb what the receiver sees
	assign rx_bus_in = line_lvl ^ spike;
endmodule // cbt_bus_line_model
`default_nettype wire

/* File: can_bit_timing_output_ctrl_tb.sv */
// self-checking bench for the bit timing and output control block
// assumes the design files and the bus line model are compiled first
`timescale 1ns/1ns
`default_nettype none
module can_bit_timing_output_ctrl_tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	cbt_pkg::cbt_wb_req_s wb_req = '0;
	cbt_pkg::cbt_wb_rsp_s wb_rsp;
	logic tx_bit = 1'b1;
	logic rx_comparator_out = 1'b1;
	logic spike = 1'b0;
	logic rx_bus_in, bus_out_a, bus_out_a_oe_n, bus_out_b, bus_out_b_oe_n;
	logic rx_bit, rx_bit_valid, bit_start;
	logic [3:0] pins;
	logic [31:0] rd;
	int n_errors = 0;
	int check_count = 0;
	int tv, tp;
	// {config, tx bit in bit 4, expected {oe_a, a, oe_b, b}}
	logic [15:0] pin_tab [12] = '{16'hda00, 16'hda15, 16'hfe05, 16'h920a,
		16'h9215, 16'h4a00, 16'h4a1a, 16'hd81a, 16'hd802, 16'hd808,
		16'hd81a, 16'hd802};
	// {prescaler, timing byte}
	logic [15:0] per_tab [3] = '{16'h0000, 16'h0112, 16'h007f};
	// {triple, spike length, expected bit}
	logic [3:0] sp_tab [3] = '{4'b0010, 4'b1011, 4'b1100};

	always #5 clk_sys = ~clk_sys;
	// floating pins compare as level 0
	assign pins = {bus_out_a_oe_n, bus_out_a & ~bus_out_a_oe_n,
		bus_out_b_oe_n, bus_out_b & ~bus_out_b_oe_n};

	cbt_top i_dut
	(
		.clk_sys(clk_sys), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.tx_bit(tx_bit), .rx_bus_in(rx_bus_in),
		.rx_comparator_out(rx_comparator_out), .bus_out_a(bus_out_a),
		.bus_out_a_oe_n(bus_out_a_oe_n), .bus_out_b(bus_out_b),
		.bus_out_b_oe_n(bus_out_b_oe_n), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .bit_start(bit_start)
	);
	cbt_bus_line_model i_line
	(
		.bus_out_a(bus_out_a), .bus_out_a_oe_n(bus_out_a_oe_n),
		.bus_out_b(bus_out_b), .bus_out_b_oe_n(bus_out_b_oe_n),
		.spike(spike), .rx_bus_in(rx_bus_in)
	);

	// =============================================
	// tasks
	task stop_test;
		if (n_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// no local limit: a slave that never acks is caught by the watchdog
	task wb_cycle(input logic we, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1,
			dat: {24'h0, d}};
		do
			@(posedge clk_sys);
		while (wb_rsp.ack !== 1'b1);
		rd = wb_rsp.dat;
		wb_req <= '0;
	endtask

	task wait_bs;
		do
			@(posedge clk_sys);
		while (bit_start !== 1'b1);
	endtask

	// registers only open while hold is set, so every change goes via hold
	task set_cfg(input logic [7:0] p, input logic [7:0] s, input logic [7:0] o);
		wb_cycle(1'b1, 6'h00, 8'h01);
		wb_cycle(1'b1, 6'h18, p);
		wb_cycle(1'b1, 6'h1c, s);
		wb_cycle(1'b1, 6'h20, o);
		wb_cycle(1'b1, 6'h00, 8'h00);
	endtask

	task run_bit(input logic tx);
		tx_bit <= tx;
		wait_bs();
		repeat (2) @(posedge clk_sys);
	endtask

	// =============================================
	// tests
	initial
	begin
		logic [7:0] p;
		logic [7:0] s;
		int tq;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		wb_cycle(1'b0, 6'h1c, 8'h00);
		chk(rd, 32'h0);
		wb_cycle(1'b1, 6'h1c, 8'ha5);
		wb_cycle(1'b0, 6'h1c, 8'h00);
		chk(rd, 32'ha5);
		wb_cycle(1'b1, 6'h20, 8'hda);
		wb_cycle(1'b0, 6'h20, 8'h00);
		chk(rd, 32'hda);
		wb_cycle(1'b0, 6'h3c, 8'h00);
		chk(rd, 32'h0);
		chk(pins, 4'b1010);
		wb_cycle(1'b1, 6'h00, 8'h00);
		wb_cycle(1'b1, 6'h1c, 8'h3c);
		wb_cycle(1'b0, 6'h1c, 8'h00);
		chk(rd, 32'h0);
		wb_cycle(1'b1, 6'h00, 8'h01);
		wb_cycle(1'b0, 6'h1c, 8'h00);
		chk(rd, 32'ha5);
		for (int i = 0; i < 3; i++)
		begin
			p = per_tab[i][15:8];
			s = per_tab[i][7:0];
			tq = 2 * (p + 1);
			set_cfg(p, s, 8'hda);
			wait_bs();
			tv = 0;
			tp = 0;
			do
			begin
				@(posedge clk_sys);
				tp++;
				if (rx_bit_valid === 1'b1)
					tv = tp;
			end
			while (bit_start !== 1'b1 && tp < 600);
			chk(tv, tq * (s[3:0] + 2) + 1);
			chk(tp, tq * (s[3:0] + s[6:4] + 3));
		end
		for (int i = 0; i < 12; i++)
		begin
			if (i == 0 || pin_tab[i][15:8] != pin_tab[i-1][15:8])
				set_cfg(8'h00, 8'h00, pin_tab[i][15:8]);
			run_bit(pin_tab[i][4]);
			chk(pins, pin_tab[i][3:0]);
		end
		set_cfg(8'h00, 8'h00, 8'hdb);
		run_bit(1'b0);
		wait_bs();
		@(posedge clk_sys);
		chk(pins, 4'b0001);
		repeat (2) @(posedge clk_sys);
		chk(pins, 4'b0000);
		set_cfg(8'h00, 8'h00, 8'hd9);
		rx_comparator_out <= 1'b0;
		run_bit(1'b0);
		chk(pins, 4'b0000);
		rx_comparator_out <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(pins, 4'b0001);
		set_cfg(8'h00, 8'h00, 8'hda);
		wb_cycle(1'b1, 6'h00, 8'h02);
		repeat (2) @(posedge clk_sys);
		chk(pins, 4'b0101);
		wb_cycle(1'b1, 6'h00, 8'h03);
		repeat (2) @(posedge clk_sys);
		chk(pins, 4'b1010);
		// a short spike at the sample point tells one sample from three
		for (int i = 0; i < 3; i++)
		begin
			tx_bit <= 1'b1;
			set_cfg(8'h00, {sp_tab[i][3], 7'h00}, 8'hda);
			wait_bs();
			repeat (4 - sp_tab[i][2:1]) @(posedge clk_sys);
			spike <= 1'b1;
			repeat (sp_tab[i][2:1]) @(posedge clk_sys);
			spike <= 1'b0;
			@(posedge clk_sys);
			chk({rx_bit_valid, rx_bit}, {1'b1, sp_tab[i][0]});
		end
		stop_test();
	end

	// =============================================
	// watchdog, well beyond the few hundred cycles the tests need
	initial
	begin
		#500000;
		n_errors++;
		stop_test();
	end
endmodule // can_bit_timing_output_ctrl_tb
`default_nettype wire
